// File: include/tmc_consts.vh
/*
  constants for the 16-bit timer/counter block: register offsets, control
  field positions, the control reset value and the compare special-event code.
  assumes inclusion by bare name from the design file.
*/
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH
`define TMC_ADDR_W        8
`define TMC_OFF_CNT_LO    8'h0e
`define TMC_OFF_CNT_HI    8'h0f
`define TMC_OFF_CTRL      8'h10
`define TMC_OFF_FLAGS     8'h0c
`define TMC_OFF_ENABLES   8'h8c
`define TMC_OFF_CMP_CFG   8'h20
`define TMC_OFF_CMP_A_LO  8'h21
`define TMC_OFF_CMP_A_HI  8'h22
`define TMC_OFF_CMP_B_LO  8'h23
`define TMC_OFF_CMP_B_HI  8'h24
`define TMC_CTRL_RUN      0
`define TMC_CTRL_CS       1
`define TMC_CTRL_SYNC_N   2
`define TMC_CTRL_OSC_EN   3
`define TMC_CTRL_PS_LO    4
`define TMC_CTRL_PS_HI    5
`define TMC_CTRL_RESET    8'h00
`define TMC_FLAG_OVF      0
`define TMC_CMP_SPECIAL   4'hb
`endif

// File: hw/tmc_timer16.v
/*
  16-bit timer/counter with prescaler, external clock input, crystal
  oscillator enable, compare special-event clear and overflow interrupt.
  assumes: one 25 MHz clock, synchronous active-low reset that stands for
  power-on/brown-out reset, single-cycle register strobes from the core.
*/
// Chosen here: the plain strobed port.
// Summary of operation
// RL1: byte reads of the count always return a stable, valid value.
// RL2: write colliding with an increment may give an unpredictable count.
// RL3: software should stop the counter before writing its bytes.
// RL4: software reads high, low, high again; rereads if highs differ.
// RL5: control bit 3 enables the crystal oscillator; runs during sleep.
// RL6: software waits its own delay for oscillator start-up.
// RL7: a compare match in special-event mode clears the count to zero.
// RL8: a special-event clear never sets the overflow flag.
// RL9: software uses timer or synchronized mode for the event clear.
// RL10: a count write in the same cycle as a clear wins.
// RL11: compare value acts as period; count wraps to zero on it.
// RL12: no reset clears the count bytes; only special events do.
// RL13: power-on reset loads control with zero: stopped, 1:1 prescale.
// RL14: writing either count byte clears the prescaler.
// RL15: low byte at 0eh, high byte at 0fh, forming the count.
// RL16: timer mode counts per cycle; else external rising edges after prescale.
// RL17: bit 1 picks timer or counter mode; bit 0 starts or stops.
// RL18: asynchronous counting keeps running in sleep; overflow can wake.
// RL19: overflow flag sets on all-ones to zero roll; sticky until cleared.
`timescale 1ns/1ps
`include "tmc_consts.vh"
`default_nettype none
module tmc_timer16 (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire [7:0] bus_addr,
  input  wire [7:0] bus_wdata,
  input  wire       bus_wr,
  input  wire       bus_rd,
  output reg  [7:0] bus_rdata,
  input  wire       ext_clock_pin,
  input  wire       sleep_mode,
  output reg        crystal_osc_enable,
  output reg        irq
);
  ////////////////////////////////////////////////////////////////////////
  reg [7:0]  ctrl_q;
  reg [15:0] count_q;
  reg [2:0]  presc_q;
  reg [7:0]  flags_q;
  reg [7:0]  enables_q;
  reg [7:0]  cmp_cfg_q;
  reg [15:0] cmp_a_q;
  reg [15:0] cmp_b_q;
  reg        ext_s1_q;
  reg        ext_s2_q;
  reg        ext_prev_q;
  reg [15:0] count_d;
  reg [2:0]  presc_d;
  reg        tick;
  reg        ovf_ev;
  reg        clr_ev;
  reg [7:0]  ctrl_d;
  reg [7:0]  flags_d;
  reg [7:0]  enables_d;
  reg [7:0]  cmp_cfg_d;
  reg [15:0] cmp_a_d;
  reg [15:0] cmp_b_d;
  reg        osc_d;
  reg        irq_d;
  wire       run      = ctrl_q[`TMC_CTRL_RUN];
  wire       ext_mode = ctrl_q[`TMC_CTRL_CS];
  wire       sync_n   = ctrl_q[`TMC_CTRL_SYNC_N];
  wire [1:0] ps_sel   = ctrl_q[`TMC_CTRL_PS_HI:`TMC_CTRL_PS_LO];
  wire       ext_rise = ext_s2_q & ~ext_prev_q;
  wire       wr_lo    = bus_wr & (bus_addr == `TMC_OFF_CNT_LO);
  wire       wr_hi    = bus_wr & (bus_addr == `TMC_OFF_CNT_HI);
  wire       cnt_wr   = wr_lo | wr_hi;
  wire       wr_ctrl  = bus_wr & (bus_addr == `TMC_OFF_CTRL);
  wire       wr_flags = bus_wr & (bus_addr == `TMC_OFF_FLAGS);
  wire       wr_enab  = bus_wr & (bus_addr == `TMC_OFF_ENABLES);
  wire       wr_cfg   = bus_wr & (bus_addr == `TMC_OFF_CMP_CFG);
  wire       wr_a_lo  = bus_wr & (bus_addr == `TMC_OFF_CMP_A_LO);
  wire       wr_a_hi  = bus_wr & (bus_addr == `TMC_OFF_CMP_A_HI);
  wire       wr_b_lo  = bus_wr & (bus_addr == `TMC_OFF_CMP_B_LO);
  wire       wr_b_hi  = bus_wr & (bus_addr == `TMC_OFF_CMP_B_HI);
  wire       match_a  = (cmp_cfg_q[3:0] == `TMC_CMP_SPECIAL) & (count_q == cmp_a_q);
  wire       match_b  = (cmp_cfg_q[7:4] == `TMC_CMP_SPECIAL) & (count_q == cmp_b_q);
  wire [2:0] ps_mask  = (ps_sel == 2'd0) ? 3'h0 :
                        (ps_sel == 2'd1) ? 3'h1 :
                        (ps_sel == 2'd2) ? 3'h3 : 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // external clock pin synchroniser
  always @(posedge clk) begin
    if (clk_en) begin
      ext_s1_q   <= ext_clock_pin;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescale, increment, clear and write
  always @* begin
    count_d = count_q;
    presc_d = presc_q;
    tick    = 1'b0;
    ovf_ev  = 1'b0;
    clr_ev  = 1'b0;
    // RL16 RL17 RL18: source, mode and run
    if (run && (!sleep_mode || (ext_mode && sync_n))) begin
      if (!ext_mode) begin
        presc_d = presc_q + 3'h1;
        tick    = ((presc_q & ps_mask) == ps_mask);
      end else if (ext_rise) begin
        presc_d = presc_q + 3'h1;
        tick    = ((presc_q & ps_mask) == ps_mask);
      end
    end
    // RL19: overflow on roll from all ones
    if (tick) begin
      count_d = count_q + 16'h0001;
      ovf_ev  = (count_q == 16'hffff);
    end
    // RL7 RL11: special event clear as period
    if (match_a || match_b) begin
      clr_ev  = 1'b1;
      count_d = 16'h0000;
      ovf_ev  = 1'b0; // RL8: clear sets no flag
    end
    // RL10 RL15: write beats the clear
    if (wr_lo) begin
      count_d = {count_q[15:8], bus_wdata};
    end
    if (wr_hi) begin
      count_d = {bus_wdata, count_q[7:0]};
    end
    // RL14: count write clears prescaler
    if (cnt_wr) begin
      presc_d = 3'h0;
    end
  end

  // RL12 RL2: count is never reset, a count write overrides a same-cycle increment
  always @(posedge clk) begin
    if (clk_en) begin
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register, top two bits read as zero
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = {2'b00, bus_wdata[5:0]};
    end
  end

  // RL13: control cleared at power-on
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `TMC_CTRL_RESET;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RL19: sticky flag, set wins over write-one-clear
  always @* begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = flags_q & ~bus_wdata;
    end
    flags_d = flags_d | {7'h00, ovf_ev};
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= 8'h00;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt mask register
  always @* begin
    enables_d = enables_q;
    if (wr_enab) begin
      enables_d = bus_wdata;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      enables_q <= 8'h00;
    end else if (clk_en) begin
      enables_q <= enables_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare mode nibbles, unit a low, unit b high
  always @* begin
    cmp_cfg_d = cmp_cfg_q;
    if (wr_cfg) begin
      cmp_cfg_d = bus_wdata;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cmp_cfg_q <= 8'h00;
    end else if (clk_en) begin
      cmp_cfg_q <= cmp_cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare value of unit a
  always @* begin
    cmp_a_d = cmp_a_q;
    if (wr_a_lo) begin
      cmp_a_d[7:0] = bus_wdata;
    end
    if (wr_a_hi) begin
      cmp_a_d[15:8] = bus_wdata;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cmp_a_q <= 16'h0000;
    end else if (clk_en) begin
      cmp_a_q <= cmp_a_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare value of unit b
  always @* begin
    cmp_b_d = cmp_b_q;
    if (wr_b_lo) begin
      cmp_b_d[7:0] = bus_wdata;
    end
    if (wr_b_hi) begin
      cmp_b_d[15:8] = bus_wdata;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cmp_b_q <= 16'h0000;
    end else if (clk_en) begin
      cmp_b_q <= cmp_b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RL14: prescaler state
  always @(posedge clk) begin
    if (!rst_n) begin
      presc_q <= 3'h0;
    end else if (clk_en) begin
      presc_q <= presc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RL5: oscillator enable follows control bit 3
  // RL18: unmasked overflow raises the wake interrupt
  always @* begin
    osc_d = ctrl_q[`TMC_CTRL_OSC_EN];
    irq_d = |(flags_q & enables_q);
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      crystal_osc_enable <= 1'b0;
      irq                <= 1'b0;
    end else if (clk_en) begin
      crystal_osc_enable <= osc_d;
      irq                <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RL1: read data from the clocked count
  always @(posedge clk) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (clk_en) begin
      bus_rdata <= 8'h00;
      if (bus_rd) begin
        case (bus_addr)
          `TMC_OFF_CNT_LO:   bus_rdata <= count_q[7:0];
          `TMC_OFF_CNT_HI:   bus_rdata <= count_q[15:8];
          `TMC_OFF_CTRL:     bus_rdata <= ctrl_q;
          `TMC_OFF_FLAGS:    bus_rdata <= flags_q;
          `TMC_OFF_ENABLES:  bus_rdata <= enables_q;
          `TMC_OFF_CMP_CFG:  bus_rdata <= cmp_cfg_q;
          `TMC_OFF_CMP_A_LO: bus_rdata <= cmp_a_q[7:0];
          `TMC_OFF_CMP_A_HI: bus_rdata <= cmp_a_q[15:8];
          `TMC_OFF_CMP_B_LO: bus_rdata <= cmp_b_q[7:0];
          `TMC_OFF_CMP_B_HI: bus_rdata <= cmp_b_q[15:8];
          default:           bus_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/tmc_ext_src.sv
/* far side model: the external count clock for tmc_timer16.
   assumes nothing of the bench clock; toggles only while run is high. */
`timescale 1ns/1ps
`default_nettype none
module tmc_ext_src (
  input  wire logic run,
  output var  logic ext_clock_pin
);
  initial ext_clock_pin = 1'b0;
  always #160 ext_clock_pin = run ? ~ext_clock_pin : 1'b0;
endmodule
`default_nettype wire

// File: dv/tmc_timer16_chk.sv
/* port checker for tmc_timer16.
   assumes a bind from the bench top, one clock, sync low reset. */
`timescale 1ns/1ps
`default_nettype none
module tmc_timer16_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic       ext_clock_pin,
  input wire logic       sleep_mode,
  input wire logic       crystal_osc_enable,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctl_wr; bus_wr && clk_en && bus_addr == 8'h10; endsequence
  sequence s_ctl_rd; bus_rd && clk_en && bus_addr == 8'h10; endsequence
  a_rdata_idle: assert property (clk_en && !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data outside slot");
  a_unmapped_zero: assert property (bus_rd && clk_en && bus_addr == 8'h30 |=> !bus_rdata)
    else $error("unmapped read not zero");
  a_ctrl_top: assert property (s_ctl_rd |=> bus_rdata[7:6] == 2'b00)
    else $error("control top bits set");
  a_ctrl_echo: assert property (s_ctl_wr ##1 s_ctl_rd |=>
    bus_rdata[5:0] == $past(bus_wdata[5:0], 2)) else $error("control readback");
  a_osc_on: assert property ((s_ctl_wr and bus_wdata[3]) ##1 !bus_wr
    |-> ##[0:1] crystal_osc_enable) else $error("osc not enabled");
  a_osc_off: assert property ((s_ctl_wr and !bus_wdata[3]) ##1 !bus_wr
    |-> ##[0:1] !crystal_osc_enable) else $error("osc not disabled");
  a_reset_out: assert property (disable iff (1'b0) !rst_n && clk_en |=>
    !irq && !crystal_osc_enable && bus_rdata == 8'h00) else $error("reset outputs");
  a_irq_sticky: assert property (irq && clk_en && !bus_wr && !$past(bus_wr) |=> irq)
    else $error("irq dropped alone");
endmodule
`default_nettype wire

// File: dv/tb.sv
/* bench top: register port driver, read queue and monitor.
   assumes tmc_ext_src drives the external count pin. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk = 0, rst_n = 0, clk_en = 1, bus_wr = 0, bus_rd = 0, sleep_mode = 0;
  logic       ext_run = 0, pend = 0, ext_clock_pin, crystal_osc_enable, irq;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, v, q[$];
  int         n_errors = 0, checks_done = 0, seed = 2;
  always #20 clk = ~clk;
  tmc_timer16 dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ext_clock_pin(ext_clock_pin), .sleep_mode(sleep_mode),
    .crystal_osc_enable(crystal_osc_enable), .irq(irq));
  tmc_ext_src src (.run(ext_run), .ext_clock_pin(ext_clock_pin));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus_rd <= 0;
    bus_wr <= 1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    q.push_back(e);
    bus_wr <= 0;
    bus_rd <= 1;
    bus_addr <= a;
    @(posedge clk);
  endtask
  task automatic idle(int n);
    bus_wr <= 0;
    bus_rd <= 0;
    repeat (n) @(posedge clk);
  endtask
  task automatic close_out;
    if (q.size() != 0) n_errors++;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (pend) chk("read data", q.pop_front(), bus_rdata);
    pend <= bus_rd;
  end
  initial begin
    #4000000;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    rd(8'h10, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h30, 8'h00);
    v = 8'($random(seed));
    wr(8'h10, v);
    rd(8'h10, v & 8'h3f);
    idle(2); // start-up wait
    chk("osc enable", {7'h0, v[3]}, {7'h0, crystal_osc_enable});
    wr(8'h10, 8'h00);
    v = 8'($random(seed));
    wr(8'h0e, v);
    wr(8'h0f, ~v);
    wr(8'h10, 8'h08);
    rst_n <= 0;
    idle(2);
    rst_n <= 1;
    rd(8'h0e, v);
    rd(8'h0f, ~v);
    rd(8'h10, 8'h00);
    wr(8'h0e, 8'hf0);
    wr(8'h0f, 8'hff);
    wr(8'h10, 8'h01);
    idle(40);
    wr(8'h10, 8'h00);
    rd(8'h0f, 8'h00);
    rd(8'h0c, 8'h01);
    chk("masked irq", 8'h00, {7'h0, irq});
    wr(8'h8c, 8'h01);
    idle(2);
    chk("irq", 8'h01, {7'h0, irq});
    wr(8'h0c, 8'h01);
    idle(2);
    chk("irq", 8'h00, {7'h0, irq});
    for (int u = 0; u < 2; u++) begin
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      wr(8'h21 + 8'(2 * u), 8'h05);
      wr(8'h22 + 8'(2 * u), 8'h00);
      wr(8'h20, u ? 8'hb0 : 8'h0b);
      wr(8'h10, 8'h01);
      idle(300);
      wr(8'h10, 8'h00);
      rd(8'h0f, 8'h00);
      rd(8'h0e, 8'h01);
      rd(8'h0c, 8'h00);
    end
    wr(8'h20, 8'h00);
    wr(8'h0e, 8'h00);
    wr(8'h0f, 8'h00);
    wr(8'h10, 8'h31);
    idle(79);
    wr(8'h10, 8'h00);
    rd(8'h0f, 8'h00);
    rd(8'h0e, 8'h0a);
    rd(8'h0f, 8'h00);
    clk_en <= 0;
    wr(8'h0e, 8'h55);
    clk_en <= 1;
    rd(8'h0e, 8'h0a);
    sleep_mode <= 1;
    ext_run <= 1;
    wr(8'h10, 8'h03);
    idle(100);
    wr(8'h10, 8'h00);
    rd(8'h0e, 8'h0a);
    wr(8'h0e, 8'h00);
    wr(8'h0f, 8'hff);
    wr(8'h10, 8'h07);
    idle(3000);
    ext_run <= 0;
    sleep_mode <= 0;
    wr(8'h10, 8'h00);
    rd(8'h0f, 8'h00);
    rd(8'h0c, 8'h01);
    idle(3);
    close_out;
  end
endmodule
bind tmc_timer16 tmc_timer16_chk u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .ext_clock_pin(ext_clock_pin), .sleep_mode(sleep_mode),
  .crystal_osc_enable(crystal_osc_enable), .irq(irq));
`default_nettype wire
